// >>> verilog/opmc_top.v
/*
 * operating power mode control: main mode register (high/middle speed)
 * and sub mode register (low speed), each with a transition flag, over
 * apb. refuses writes under the documented interlocks.
 * assumes sleep, flash p/e and oscillator status arrive as levels
 * synchronous to pclk.
 */
// Local design decision: the APB slave port.
`include "opmc_defs.vh"

module opmc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        sysctl_write_enable,
  input  wire        sleep_active,
  input  wire        flash_pe_busy,
  input  wire        pll_stop_bit,
  input  wire        fast_osc_stop_bit,
  input  wire        fast_osc_force_on,
  input  wire        main_osc_stop_bit,
  input  wire        slow_osc_stop_bit,
  output wire [2:0]  active_mode_select,
  output wire        active_low_speed,
  output wire        main_transition_flag,
  output wire        sub_transition_flag
);
  reg  [2:0] power_mode_select_q;
  reg  [2:0] power_mode_select_d;
  reg  [2:0] applied_mode_q;
  reg        low_speed_select_q;
  reg        low_speed_select_d;
  reg        applied_low_q;
  reg        main_start;
  reg        sub_start;
  reg  [7:0] mode_rd;
  reg  [7:0] sub_rd;
  wire       hit_mode;
  wire       hit_sub;
  wire       wr_en;
  wire       rd_en;
  wire       main_busy;
  wire       main_done;
  wire       sub_busy;
  wire       sub_done;
  wire       wr_mode_ok;
  wire       wr_sub_ok;
  wire       osc_running;
  wire [7:0] lane_mode;
  wire [7:0] lane_sub;

  opmc_apb_if u_apb (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .hit_mode (hit_mode),
    .hit_sub  (hit_sub),
    .wr_en    (wr_en),
    .rd_en    (rd_en)
  );

  opmc_settle u_main_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (main_start),
    .busy    (main_busy),
    .done    (main_done)
  );

  opmc_settle u_sub_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sub_start),
    .busy    (sub_busy),
    .done    (sub_done)
  );

  assign main_transition_flag = main_busy;
  assign sub_transition_flag  = sub_busy;
  assign active_mode_select   = applied_mode_q;
  assign active_low_speed     = applied_low_q;

  // each register sits in byte lane 0 of its own word
  assign lane_mode = pwdata[7:0];
  assign lane_sub  = pwdata[7:0];

  // protect bit gates both registers; silently ignored otherwise
  assign wr_mode_ok = wr_en && hit_mode && pstrb[0] && sysctl_write_enable
                      && !main_busy
                      && !sleep_active
                      && !low_speed_select_q
                      && !flash_pe_busy;

  assign wr_sub_ok  = wr_en && hit_sub && pstrb[0] && sysctl_write_enable
                      && !sub_busy
                      && !sleep_active
                      && !flash_pe_busy;

  // any running source, the slow oscillator included, blocks the move into low speed
  assign osc_running = !pll_stop_bit || !fast_osc_stop_bit
                       || fast_osc_force_on || !main_osc_stop_bit
                       || !slow_osc_stop_bit;

  always @* begin
    power_mode_select_d = power_mode_select_q;
    main_start          = 1'b0;
    // illegal codes are dropped so the field only ever holds 000 or 010
    if (wr_mode_ok &&
        ((lane_mode[2:0] == `OPMC_MODE_HIGH) ||
         (lane_mode[2:0] == `OPMC_MODE_MIDDLE))) begin
      power_mode_select_d = lane_mode[`OPMC_SEL_MSB:`OPMC_SEL_LSB];
      main_start          = 1'b1;
    end
  end

  always @* begin
    low_speed_select_d = low_speed_select_q;
    sub_start          = 1'b0;
    if (wr_sub_ok) begin
      if (lane_sub[`OPMC_LSS_BIT] && !osc_running) begin
        low_speed_select_d = 1'b1;
        sub_start          = 1'b1;
      end else if (!lane_sub[`OPMC_LSS_BIT]) begin
        low_speed_select_d = 1'b0;
        sub_start          = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode_select_q <= `OPMC_MODE_RESET;
      applied_mode_q      <= `OPMC_MODE_RESET;
      low_speed_select_q  <= 1'b0;
      applied_low_q       <= 1'b0;
    end else begin
      power_mode_select_q <= power_mode_select_d;
      low_speed_select_q  <= low_speed_select_d;
      // new mode takes effect only once settling has run out
      if (main_done) begin
        applied_mode_q <= power_mode_select_q;
      end
      if (sub_done) begin
        applied_low_q <= low_speed_select_q;
      end
    end
  end

  always @* begin
    mode_rd = 8'h00;
    mode_rd[`OPMC_SEL_MSB:`OPMC_SEL_LSB] = power_mode_select_q;
    mode_rd[`OPMC_TSF_BIT] = main_busy;
    sub_rd = 8'h00;
    sub_rd[`OPMC_LSS_BIT] = low_speed_select_q;
    sub_rd[`OPMC_TSF_BIT] = sub_busy;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      // latched in setup so data is steady through the access phase
      if (hit_mode) begin
        prdata <= {24'h000000, mode_rd};
      end else if (hit_sub) begin
        prdata <= {24'h000000, sub_rd};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  wire unused_rd;
  assign unused_rd = rd_en;
endmodule // opmc_top

// >>> verilog/opmc_defs.vh
/*
 * constants for the operating power mode control block: register indices
 * and byte addresses, field positions, mode codes and settling counts.
 * assumes a 250 MHz pclk; included by bare name.
 */
`ifndef OPMC_DEFS_VH
`define OPMC_DEFS_VH

// register indices; each register owns one word at four times its index
`define OPMC_IDX_MODE_CTRL     32'h000800a0
`define OPMC_IDX_SUB_CTRL      32'h000800aa
`define OPMC_ADDR_WORD_MODE    32'h00200280
`define OPMC_ADDR_WORD_SUB     32'h002002a8

`define OPMC_SEL_MSB           2
`define OPMC_SEL_LSB           0
`define OPMC_TSF_BIT           4
`define OPMC_LSS_BIT           0

`define OPMC_MODE_HIGH         3'h0
`define OPMC_MODE_MIDDLE       3'h2
`define OPMC_MODE_RESET        3'h2

`define OPMC_SETTLE_NS         1000
`define OPMC_CLK_PERIOD_NS     4
`define OPMC_SETTLE_CYCLES \
  ((`OPMC_SETTLE_NS + `OPMC_CLK_PERIOD_NS - 1) / `OPMC_CLK_PERIOD_NS)
`define OPMC_CNT_W             9

`endif

// >>> verilog/opmc_settle.v
/*
 * settling timer: a start pulse raises busy, which stays high for a
 * fixed number of cycles and then drops with a one-cycle done pulse.
 * assumes one pclk domain and no start while busy.
 */
`include "opmc_defs.vh"

module opmc_settle (
  input  wire pclk,
  input  wire presetn,
  input  wire start,
  output wire busy,
  output wire done
);
  localparam integer           LAST_I = `OPMC_SETTLE_CYCLES - 1;
  localparam [`OPMC_CNT_W-1:0] LAST   = LAST_I[`OPMC_CNT_W-1:0];

  reg [`OPMC_CNT_W-1:0] cnt_q;
  reg                   busy_q;

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= {`OPMC_CNT_W{1'b0}};
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q  <= {`OPMC_CNT_W{1'b0}};
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // opmc_settle

// >>> verilog/opmc_apb_if.v
/*
 * apb slave front end: decodes the two word-aligned registers and turns
 * a completed access phase into one-cycle strobes. zero wait states.
 * assumes an apb3 master on pclk; pslverr flags unmapped addresses.
 */
`include "opmc_defs.vh"

module opmc_apb_if (
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  output wire        pready,
  output wire        pslverr,
  output wire        hit_mode,
  output wire        hit_sub,
  output wire        wr_en,
  output wire        rd_en
);
  wire [31:0] word_addr;
  wire        access;

  assign word_addr = {paddr[31:2], 2'b00};
  assign access    = psel && penable;
  assign hit_mode  = (word_addr == `OPMC_ADDR_WORD_MODE);
  assign hit_sub   = (word_addr == `OPMC_ADDR_WORD_SUB);
  assign pready    = 1'b1;
  assign pslverr   = access && !(hit_mode || hit_sub);
  assign wr_en     = access && pwrite;
  assign rd_en     = access && !pwrite;
endmodule // opmc_apb_if

// >>> tb/opmc_top_props.sv
/* assertions on opmc_top ports: flag width, mode apply, write locks.
   assumes bind to opmc_top; settle count from opmc_defs.vh. */
`include "opmc_defs.vh"
module opmc_top_props
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        sysctl_write_enable,
  input wire        sleep_active,
  input wire        flash_pe_busy,
  input wire        pll_stop_bit,
  input wire        fast_osc_stop_bit,
  input wire        fast_osc_force_on,
  input wire        main_osc_stop_bit,
  input wire        slow_osc_stop_bit,
  input wire [2:0]  active_mode_select,
  input wire        active_low_speed,
  input wire        main_transition_flag,
  input wire        sub_transition_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SET = `OPMC_SETTLE_CYCLES;
  logic [8:0] cm_q, cs_q;
  logic [2:0] mv_q;
  logic       sv_q;
  wire mf = main_transition_flag;
  wire sf = sub_transition_flag;
  wire wr = psel & penable & pwrite & sysctl_write_enable
          & ~sleep_active & ~flash_pe_busy;
  // sv_q mirrors the low speed select bit, which locks the main register
  wire okm = wr & paddr == `OPMC_ADDR_WORD_MODE & pstrb[0] & ~mf & ~sv_q
           & (pwdata[2:0] == 3'h0 | pwdata[2:0] == 3'h2);
  wire osc = ~pll_stop_bit | ~fast_osc_stop_bit | ~main_osc_stop_bit
           | ~slow_osc_stop_bit | fast_osc_force_on;
  wire oks = wr & paddr == `OPMC_ADDR_WORD_SUB & pstrb[0] & ~sf;
  wire go_s = oks & (~pwdata[0] | ~osc);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_q <= 9'h0;
      cs_q <= 9'h0;
      mv_q <= 3'h2;
      sv_q <= 1'b0;
    end else begin
      cm_q <= mf ? cm_q + 9'h1 : 9'h0;
      cs_q <= sf ? cs_q + 9'h1 : 9'h0;
      if (okm) mv_q <= pwdata[2:0];
      if (go_s) sv_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_main_settle: assert property ($fell(mf) |-> cm_q == SET)
    else $error("main flag width wrong");
  chk_sub_settle: assert property ($fell(sf) |-> cs_q == SET)
    else $error("sub flag width wrong");
  chk_main_apply: assert property (
    $fell(mf) |-> active_mode_select == mv_q)
    else $error("mode not applied");
  chk_sub_apply: assert property (
    $fell(sf) |-> active_low_speed == sv_q)
    else $error("low speed not applied");
  chk_main_start: assert property (okm && pwdata[2:0] != mv_q |=> mf)
    else $error("main flag not set");
  chk_sub_start: assert property (go_s |=> sf)
    else $error("sub flag not set");
  chk_osc_lock: assert property (oks && pwdata[0] && osc |=> !sf)
    else $error("low speed taken with osc on");
  chk_lock_hold: assert property (
    psel && penable && pwrite && !mf && !sf
    && (sleep_active || flash_pe_busy) |=> !mf && !sf)
    else $error("write taken while locked");
  chk_mode_legal: assert property (
    active_mode_select inside {3'h0, 3'h2})
    else $error("illegal mode applied");
endmodule // opmc_top_props
bind opmc_top opmc_top_props u_opmc_top_props (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .pstrb                (pstrb),
  .sysctl_write_enable  (sysctl_write_enable),
  .sleep_active         (sleep_active),
  .flash_pe_busy        (flash_pe_busy),
  .pll_stop_bit         (pll_stop_bit),
  .fast_osc_stop_bit    (fast_osc_stop_bit),
  .fast_osc_force_on    (fast_osc_force_on),
  .main_osc_stop_bit    (main_osc_stop_bit),
  .slow_osc_stop_bit    (slow_osc_stop_bit),
  .active_mode_select   (active_mode_select),
  .active_low_speed     (active_low_speed),
  .main_transition_flag (main_transition_flag),
  .sub_transition_flag  (sub_transition_flag)
);

// >>> tb/tb.sv
/* bench for opmc_top: register rows, then locks and reset cases.
   assumes zero wait apb and the settle count of opmc_defs.vh. */
`include "opmc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MA = `OPMC_ADDR_WORD_MODE;
  localparam logic [31:0] SA = `OPMC_ADDR_WORD_SUB;
  typedef struct {logic [31:0] a, d, r; logic [3:0] s, act;} opmc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        we, slp, fpe, pll, fst, fon, mst, sst, mf, sf, lsp;
  logic [2:0]  msel;
  int          bad_count, check_count, k;
  int          cyc = 0;
  opmc_row_t   rows[7] = '{'{MA, 0, 0, 1, 0}, '{MA, 'hfa, 2, 1, 2},
    '{MA, 5, 2, 1, 2}, '{MA, 0, 2, 'he, 2}, '{SA, 'hff, 1, 1, 'ha},
    '{MA, 0, 2, 1, 'ha}, '{SA, 0, 0, 1, 2}};
  opmc_top u_opmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysctl_write_enable(we), .sleep_active(slp), .flash_pe_busy(fpe),
    .pll_stop_bit(pll), .fast_osc_stop_bit(fst), .fast_osc_force_on(fon),
    .main_osc_stop_bit(mst), .slow_osc_stop_bit(sst),
    .active_mode_select(msel), .active_low_speed(lsp),
    .main_transition_flag(mf), .sub_transition_flag(sf));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // flags rise one edge after the write, so skip that edge first
  // software side: wait for both flags low before going on
  task idle;
    @(posedge pclk);
    for (int j = 0; j < 300 && (mf | sf) !== 1'b0; j++) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, slp, fpe, fon, paddr, pwdata} = 0;
    // every oscillator stop bit set, force-on low; no flash transfer runs here
    {we, pll, fst, mst, sst} = 5'h1f;
    pstrb = 4'h0;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, MA, 0, 0); chk(rd, 2);
    apb(0, SA, 0, 0); chk(rd, 0);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d, rows[i].s);
      idle;
      apb(0, rows[i].a, 0, 0); chk(rd, rows[i].r);
      chk({lsp, msel}, rows[i].act);
    end
    apb(1, MA, 0, 1); apb(0, MA, 0, 0); chk(rd & 'h10, 'h10);
    apb(1, MA, 2, 1); idle; chk(msel, 0);
    apb(1, SA, 1, 1); apb(1, SA, 0, 1); idle; chk(lsp, 1);
    apb(1, SA, 0, 1); idle; chk(lsp, 0);
    for (k = 0; k < 3; k++) begin
      {slp, fpe, we} <= {k == 0, k == 1, k != 2};
      apb(1, MA, 2, 1); apb(1, SA, 1, 1);
      @(posedge pclk); chk({mf, sf}, 0);
    end
    {slp, fpe, we} <= 3'h1;
    for (k = 0; k < 5; k++) begin
      {pll, fst, mst, sst, fon} <= {4'hf ^ (4'h1 << k), k == 4};
      apb(1, SA, 1, 1); @(posedge pclk); chk(sf, 0);
    end
    {pll, fst, mst, sst, fon} <= 5'h1e;
    apb(0, 'h00200284, 0, 0); chk(err, 1);
    apb(1, SA, 1, 1); repeat (3) @(posedge pclk);
    presetn <= 0;
    @(posedge pclk); chk({sf, lsp, msel}, 2);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, SA, 0, 0); chk(rd, 0);
    apb(0, MA, 0, 0); chk(rd, 2);
    finish_test;
  end
endmodule // tb
